// ---- design/tca_regs.svh ----
`ifndef TCA_REGS_SVH
`define TCA_REGS_SVH

// ----------------------------------------------------------------
// Descriptor layout in on-chip RAM
// ----------------------------------------------------------------
`define TCA_DESC_WORDS     3'h6
`define TCA_DESC_LAST_WORD 3'h5
`define TCA_DESC_BYTES     24'h00000c
`define TCA_WORD_STEP      24'h000002
`define TCA_W_MODE_A       3'h0
`define TCA_W_SRC_LO       3'h1
`define TCA_W_MODE_B       3'h2
`define TCA_W_DST_LO       3'h3
`define TCA_W_COUNT_A      3'h4
`define TCA_W_COUNT_B      3'h5

// ----------------------------------------------------------------
// Vector table and soft vector register
// ----------------------------------------------------------------
`define TCA_VEC_BASE       24'h000400
`define TCA_RAM_PAGE       8'hff
`define TCA_SV_ACT_BIT     7
`define TCA_SV_RESET       8'h00

// ----------------------------------------------------------------
// Mode field encodings
// ----------------------------------------------------------------
`define TCA_AC_FIXED       2'h0
`define TCA_AC_INC         2'h2
`define TCA_AC_DEC         2'h3
`define TCA_MD_NORMAL      2'h0
`define TCA_MD_REPEAT      2'h1
`define TCA_MD_BLOCK       2'h2
`define TCA_STEP_BYTE      24'h000001
`define TCA_STEP_WORD      24'h000002

`endif

// ---- design/tca_pkg.sv ----
package tca_pkg;

	// ----------------------------------------------------------------
	// Sequencer states, Gray coded along the transfer path
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		TCA_IDLE     = 3'h0,
		TCA_VEC_RD   = 3'h1,
		TCA_DESC_RD  = 3'h3,
		TCA_DATA_RD  = 3'h2,
		TCA_DATA_WR  = 3'h6,
		TCA_DESC_WR  = 3'h7,
		TCA_FINISH   = 3'h5
	} tca_state_type;

	typedef struct packed {
		logic [1:0] src_addr_ctl;
		logic [1:0] dst_addr_ctl;
		logic [1:0] xfer_mode;
		logic       repeat_area_side;
		logic       word_size_bit;
	} tca_mode_a_type;

	typedef struct packed {
		logic       chain_bit;
		logic       per_transfer_irq_select;
		logic [5:0] spare;
	} tca_mode_b_type;

	typedef struct packed {
		logic        req;
		logic        we;
		logic        word;
		logic [23:0] addr;
		logic [15:0] wdata;
	} tca_mem_req_type;

endpackage : tca_pkg

// ---- design/tca_ctl.sv ----
`timescale 1ns/1ns
`include "tca_regs.svh"

// Overview of operation
// - Enabled selected interrupt starts its descriptor transfer
// - Interrupt end: clear enable, forward interrupt
// - Soft, no select, not last: clear bit
// - Soft select or count end: keep bit, interrupt
// - Non-last transfer without select clears the source flag
// - Count end: flag kept, enable cleared, forwarded
// - Normal mode steps addresses, decrements count
// - Chain: end actions only when chain bit zero
// - Chain bit reads next descriptor consecutively
// - Address control: 00 fixed, 10 increment
// - Mode: 00 normal, 01 repeat, 10 block
// - Size bit: 0 byte, 1 word
// - Area side bit 1 selects source area
// - Halted after reset until module stop cleared
// - Chained descriptor: no interrupt, flag untouched
module tca_ctl #(
	parameter int          N_SRC         = 8,
	parameter logic [6:0]  SRC_VEC_FIRST = 7'h10
) (
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic                     ce,
	input  wire logic                     module_stop_wr,
	input  wire logic                     module_stop_data,
	input  wire logic [N_SRC-1:0]         irq_req,
	input  wire logic                     te_wr,
	input  wire logic                     te_set,
	input  wire logic [$clog2(N_SRC)-1:0] te_idx,
	input  wire logic                     te_bulk_wr,
	input  wire logic [N_SRC-1:0]         te_bulk_data,
	input  wire logic                     sv_wr,
	input  wire logic [7:0]               sv_wdata,
	input  wire logic                     mem_ack,
	input  wire logic [15:0]              mem_rdata,
	output tca_pkg::tca_mem_req_type      mem,
	output logic                          module_stop,
	output logic [N_SRC-1:0]              transfer_enable_bank,
	output logic [7:0]                    soft_vector_register,
	output logic                          soft_transfer_end_irq,
	output logic [N_SRC-1:0]              cpu_irq,
	output logic [N_SRC-1:0]              flag_clear,
	output logic                          busy
);

	localparam int IW = $clog2(N_SRC);

	// ----------------------------------------------------------------
	// Address arithmetic
	// ----------------------------------------------------------------
	function automatic logic [23:0] step_of(input logic word);
		step_of = word ? `TCA_STEP_WORD : `TCA_STEP_BYTE;
	endfunction : step_of

	function automatic logic [23:0] addr_step(input logic [23:0] ptr, input logic [1:0] ctl,
			input logic word);
		unique case (ctl)
			`TCA_AC_INC: addr_step = ptr + step_of(word);
			`TCA_AC_DEC: addr_step = ptr - step_of(word);
			default:     addr_step = ptr;
		endcase
	endfunction : addr_step

	// Rewinds an area pointer by one full area; size 0 stands for 256
	function automatic logic [23:0] addr_rewind(input logic [23:0] ptr, input logic [1:0] ctl,
			input logic word, input logic [7:0] size);
		logic [23:0] span;
		span = {15'h0000, size == 8'h00, size} << word;
		unique case (ctl)
			`TCA_AC_INC: addr_rewind = ptr - span;
			`TCA_AC_DEC: addr_rewind = ptr + span;
			default:     addr_rewind = ptr;
		endcase
	endfunction : addr_rewind

	// ----------------------------------------------------------------
	// Sequencer state
	// ----------------------------------------------------------------
	tca_pkg::tca_state_type  state;
	tca_pkg::tca_mode_a_type mode_word_a;
	tca_pkg::tca_mode_b_type mode_word_b;
	logic [23:0]             source_pointer;
	logic [23:0]             dest_pointer;
	logic [15:0]             count_word_a;
	logic [15:0]             count_word_b;
	logic [15:0]             data;
	logic [23:0]             desc_addr;
	logic [2:0]              word_idx;
	logic [IW-1:0]           active_src;
	logic                    soft_run;
	logic                    last;
	logic                    end_stop;
	logic                    soft_served;

	logic [N_SRC-1:0] pending;
	logic [IW-1:0]    pick;
	logic             soft_pending;
	logic             area_src;
	logic             block_end;
	logic [7:0]       next_low;
	logic [23:0]      next_src;
	logic [23:0]      next_dst;

	assign pending      = irq_req & transfer_enable_bank & ~flag_clear;
	assign soft_pending = soft_vector_register[`TCA_SV_ACT_BIT] & ~soft_served;
	assign area_src     = mode_word_a.repeat_area_side;
	assign next_low     = count_word_a[7:0] - 8'h01;
	assign block_end    = next_low == 8'h00;

	always_comb begin
		pick = '0;
		for (int i = N_SRC - 1; i >= 0; i--) begin
			if (pending[i]) begin
				pick = IW'(i);
			end
		end
	end

	// Pointer values after one data move, area rewound at its end
	always_comb begin
		next_src = addr_step(source_pointer, mode_word_a.src_addr_ctl, mode_word_a.word_size_bit);
		next_dst = addr_step(dest_pointer, mode_word_a.dst_addr_ctl, mode_word_a.word_size_bit);
		if (mode_word_a.xfer_mode != `TCA_MD_NORMAL && block_end) begin
			if (area_src) begin
				next_src = addr_rewind(next_src, mode_word_a.src_addr_ctl,
					mode_word_a.word_size_bit, count_word_a[15:8]);
			end else begin
				next_dst = addr_rewind(next_dst, mode_word_a.dst_addr_ctl,
					mode_word_a.word_size_bit, count_word_a[15:8]);
			end
		end
	end

	function automatic logic [15:0] desc_word(input logic [2:0] idx,
			input tca_pkg::tca_mode_a_type ma, input tca_pkg::tca_mode_b_type mb,
			input logic [23:0] sp, input logic [23:0] dp, input logic [15:0] ca,
			input logic [15:0] cb);
		unique case (idx)
			`TCA_W_MODE_A:  desc_word = {ma, sp[23:16]};
			`TCA_W_SRC_LO:  desc_word = sp[15:0];
			`TCA_W_MODE_B:  desc_word = {mb, dp[23:16]};
			`TCA_W_DST_LO:  desc_word = dp[15:0];
			`TCA_W_COUNT_A: desc_word = ca;
			default:        desc_word = cb;
		endcase
	endfunction : desc_word

	// ----------------------------------------------------------------
	// Transfer sequencer and memory master
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			state          <= tca_pkg::TCA_IDLE;
			mem            <= '0;
			mode_word_a    <= '0;
			mode_word_b    <= '0;
			source_pointer <= '0;
			dest_pointer   <= '0;
			count_word_a   <= '0;
			count_word_b   <= '0;
			data           <= '0;
			desc_addr      <= '0;
			word_idx       <= '0;
			active_src     <= '0;
			soft_run       <= 1'b0;
			last           <= 1'b0;
			end_stop       <= 1'b0;
			busy           <= 1'b0;
		end else if (ce) begin
			unique case (state)
				tca_pkg::TCA_IDLE: begin
					// Module stop holds off every new activation
					if (!module_stop && (pending != '0 || soft_pending)) begin
						state      <= tca_pkg::TCA_VEC_RD;
						busy       <= 1'b1;
						soft_run   <= pending == '0;
						active_src <= pick;
						last       <= 1'b0;
						mem.req    <= 1'b1;
						mem.we     <= 1'b0;
						mem.word   <= 1'b1;
						mem.addr   <= `TCA_VEC_BASE + {16'h0000, (pending != '0) ?
							SRC_VEC_FIRST + 7'(pick) : soft_vector_register[6:0], 1'b0};
					end
				end
				tca_pkg::TCA_VEC_RD: begin
					if (mem_ack) begin
						desc_addr <= {`TCA_RAM_PAGE, mem_rdata};
						mem.addr  <= {`TCA_RAM_PAGE, mem_rdata};
						word_idx  <= '0;
						state     <= tca_pkg::TCA_DESC_RD;
					end
				end
				tca_pkg::TCA_DESC_RD: begin
					if (mem_ack) begin
						unique case (word_idx)
							`TCA_W_MODE_A: begin
								mode_word_a           <= mem_rdata[15:8];
								source_pointer[23:16] <= mem_rdata[7:0];
							end
							`TCA_W_SRC_LO: source_pointer[15:0] <= mem_rdata;
							`TCA_W_MODE_B: begin
								mode_word_b         <= mem_rdata[15:8];
								dest_pointer[23:16] <= mem_rdata[7:0];
							end
							`TCA_W_DST_LO:  dest_pointer[15:0] <= mem_rdata;
							`TCA_W_COUNT_A: count_word_a       <= mem_rdata;
							default:        count_word_b       <= mem_rdata;
						endcase
						if (word_idx == `TCA_DESC_LAST_WORD) begin
							state     <= tca_pkg::TCA_DATA_RD;
							mem.addr  <= (word_idx == `TCA_W_MODE_A) ? '0 : source_pointer;
							mem.word  <= mode_word_a.word_size_bit;
						end else begin
							word_idx <= word_idx + 3'h1;
							mem.addr <= mem.addr + `TCA_WORD_STEP;
						end
					end
				end
				tca_pkg::TCA_DATA_RD: begin
					if (mem_ack) begin
						data      <= mem_rdata;
						mem.we    <= 1'b1;
						mem.addr  <= dest_pointer;
						mem.wdata <= mem_rdata;
						state     <= tca_pkg::TCA_DATA_WR;
					end
				end
				tca_pkg::TCA_DATA_WR: begin
					if (mem_ack) begin
						source_pointer <= next_src;
						dest_pointer   <= next_dst;
						unique case (mode_word_a.xfer_mode)
							`TCA_MD_NORMAL: begin
								count_word_a <= count_word_a - 16'h0001;
								last         <= count_word_a == 16'h0001;
							end
							`TCA_MD_REPEAT: begin
								count_word_a[7:0] <= block_end ? count_word_a[15:8] : next_low;
							end
							default: begin
								// Both count halves carry the block size
								count_word_a[7:0] <= block_end ? count_word_a[15:8] : next_low;
								if (block_end) begin
									count_word_b <= count_word_b - 16'h0001;
									last         <= count_word_b == 16'h0001;
								end
							end
						endcase
						if (mode_word_a.xfer_mode == `TCA_MD_BLOCK && !block_end) begin
							mem.we   <= 1'b0;
							mem.addr <= next_src;
							state    <= tca_pkg::TCA_DATA_RD;
						end else begin
							mem.word  <= 1'b1;
							mem.addr  <= desc_addr;
							// First write-back word set with the request so it stands until ack
							mem.wdata <= desc_word(`TCA_W_MODE_A, mode_word_a, mode_word_b,
								next_src, next_dst, count_word_a, count_word_b);
							word_idx  <= '0;
							state     <= tca_pkg::TCA_DESC_WR;
						end
					end
				end
				tca_pkg::TCA_DESC_WR: begin
					if (mem_ack) begin
						if (word_idx == `TCA_DESC_LAST_WORD) begin
							if (mode_word_b.chain_bit) begin
								// Next descriptor sits right after this one
								desc_addr <= desc_addr + `TCA_DESC_BYTES;
								mem.addr  <= desc_addr + `TCA_DESC_BYTES;
								mem.we    <= 1'b0;
								word_idx  <= '0;
								last      <= 1'b0;
								state     <= tca_pkg::TCA_DESC_RD;
							end else begin
								end_stop <= last | mode_word_b.per_transfer_irq_select;
								mem      <= '0;
								state    <= tca_pkg::TCA_FINISH;
							end
						end else begin
							word_idx  <= word_idx + 3'h1;
							mem.addr  <= mem.addr + `TCA_WORD_STEP;
							mem.wdata <= desc_word(word_idx + 3'h1, mode_word_a, mode_word_b,
								source_pointer, dest_pointer, count_word_a, count_word_b);
						end
					end else begin
						mem.wdata <= desc_word(word_idx, mode_word_a, mode_word_b,
							source_pointer, dest_pointer, count_word_a, count_word_b);
					end
				end
				tca_pkg::TCA_FINISH: begin
					// One spare cycle lets the clear pulse mask the source flag at rearbitration
					busy  <= 1'b0;
					state <= tca_pkg::TCA_IDLE;
				end
				default: begin
					mem   <= '0;
					busy  <= 1'b0;
					state <= tca_pkg::TCA_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Module stop, set after reset
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			module_stop <= 1'b1;
		end else if (ce && module_stop_wr) begin
			module_stop <= module_stop_data;
		end
	end

	// ----------------------------------------------------------------
	// Transfer enable bank
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			transfer_enable_bank <= '0;
		end else if (ce) begin
			if (state == tca_pkg::TCA_FINISH && !soft_run && end_stop) begin
				transfer_enable_bank[active_src] <= 1'b0;
			end
			// Host set placed last so it wins over a same-cycle clear
			if (!module_stop && te_bulk_wr) begin
				transfer_enable_bank <= te_bulk_data;
			end else if (!module_stop && te_wr) begin
				transfer_enable_bank[te_idx] <= te_set;
			end
		end
	end

	// ----------------------------------------------------------------
	// Soft vector register and end interrupt
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			soft_vector_register  <= `TCA_SV_RESET;
			soft_served           <= 1'b0;
			soft_transfer_end_irq <= 1'b0;
		end else if (ce) begin
			if (state == tca_pkg::TCA_FINISH && soft_run) begin
				if (end_stop) begin
					soft_served           <= 1'b1;
					soft_transfer_end_irq <= 1'b1;
				end else begin
					soft_vector_register[`TCA_SV_ACT_BIT] <= 1'b0;
				end
			end
			// Vector frozen while a soft transfer is under way
			if (sv_wr && !module_stop && !(busy && soft_run)) begin
				soft_vector_register <= sv_wdata;
				if (!sv_wdata[`TCA_SV_ACT_BIT]) begin
					soft_served           <= 1'b0;
					soft_transfer_end_irq <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Source flag clear and CPU interrupt pass-through
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			flag_clear <= '0;
		end else if (ce) begin
			flag_clear <= '0;
			if (state == tca_pkg::TCA_FINISH && !soft_run && !end_stop) begin
				flag_clear[active_src] <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cpu_irq <= '0;
		end else if (ce) begin
			// Kept flag plus cleared enable forwards the source at the end
			cpu_irq <= irq_req & ~transfer_enable_bank;
		end
	end

endmodule : tca_ctl

// ---- tb/tca_ctl_props.sv ----
`timescale 1ns/1ns
module tca_ctl_props #(
	parameter int N_SRC = 8
) (
	input wire logic                     clk,
	input wire logic                     rst,
	input wire logic                     ce,
	input wire logic [N_SRC-1:0]         irq_req,
	input wire logic                     te_wr,
	input wire logic                     te_bulk_wr,
	input wire logic                     sv_wr,
	input wire logic                     mem_ack,
	input wire tca_pkg::tca_mem_req_type mem,
	input wire logic                     module_stop,
	input wire logic [N_SRC-1:0]         transfer_enable_bank,
	input wire logic [7:0]               soft_vector_register,
	input wire logic                     soft_transfer_end_irq,
	input wire logic [N_SRC-1:0]         cpu_irq,
	input wire logic [N_SRC-1:0]         flag_clear,
	input wire logic                     busy
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// ------
	// Sequence steps
	// ------
	sequence s_start;
		$rose(busy);
	endsequence
	sequence s_end;
		$fell(busy);
	endsequence
	sequence s_vec_read;
		mem.req && !mem.we && mem.word && mem.addr[23:8] == 16'h0004;
	endsequence
	// ------
	// Checks
	// ------
	a_vec_first: assert property (s_start |-> ##[0:2] s_vec_read)
		else $error("activation did not begin with a vector read");
	a_mem_hold: assert property (mem.req && !mem_ack |=> mem.req && $stable(mem))
		else $error("memory request changed before acknowledge");
	a_cpu_pass: assert property (!$past(rst) && $past(ce) |->
		cpu_irq == $past(irq_req & ~transfer_enable_bank))
		else $error("cpu request does not follow disabled flags");
	a_clear_at_end: assert property (|flag_clear |-> s_end)
		else $error("flag clear outside sequence end");
	a_clear_onehot: assert property (|flag_clear |-> $onehot(flag_clear) &&
		(flag_clear & ~transfer_enable_bank) == '0)
		else $error("flag clear on wrong source");
	a_en_hw_clear: assert property (!$past(rst) && !$past(te_wr) && !$past(te_bulk_wr) &&
		|($past(transfer_enable_bank) & ~transfer_enable_bank) |-> s_end ##0 flag_clear == '0)
		else $error("enable cleared outside count end");
	a_soft_end: assert property ($rose(soft_transfer_end_irq) |->
		soft_vector_register[7] ##0 s_end)
		else $error("soft end interrupt without kept bit");
	a_soft_clear: assert property (!$past(rst) && !$past(sv_wr) &&
		$fell(soft_vector_register[7]) |-> !soft_transfer_end_irq ##0 s_end)
		else $error("soft bit cleared at wrong time");
	a_halt_idle: assert property (module_stop && !busy |=> !busy)
		else $error("activity while halted");
	a_halt_ignore: assert property (module_stop && (te_wr || te_bulk_wr || sv_wr) |=>
		$stable(transfer_enable_bank) && $stable(soft_vector_register))
		else $error("host write taken while halted");
endmodule : tca_ctl_props

bind tca_ctl tca_ctl_props #(.N_SRC(N_SRC)) u_tca_ctl_props (
	.clk(clk), .rst(rst), .ce(ce), .irq_req(irq_req), .te_wr(te_wr),
	.te_bulk_wr(te_bulk_wr), .sv_wr(sv_wr), .mem_ack(mem_ack), .mem(mem),
	.module_stop(module_stop), .transfer_enable_bank(transfer_enable_bank),
	.soft_vector_register(soft_vector_register), .busy(busy),
	.soft_transfer_end_irq(soft_transfer_end_irq), .cpu_irq(cpu_irq), .flag_clear(flag_clear)
);

// ---- tb/tca_mem_model.sv ----
`timescale 1ns/1ns
module tca_mem_model (
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire tca_pkg::tca_mem_req_type mem,
	input  wire logic [1:0]               delay,
	output logic                          mem_ack,
	output logic [15:0]                   mem_rdata
);
	logic [15:0] store [logic [23:0]];
	logic [1:0]  waited;
	// Idle data toggles so a stale word never looks valid
	always @(posedge clk) begin
		if (rst || !mem.req || mem_ack) begin
			if (!rst && mem.req && mem_ack && mem.we)
				store[mem.addr] = mem.word ? mem.wdata : {8'h00, mem.wdata[7:0]};
			mem_ack <= 1'b0;
			waited <= 2'h0;
			mem_rdata <= rst ? 16'h0000 : ~mem_rdata;
		end else if (waited >= delay) begin
			mem_ack <= 1'b1;
			mem_rdata <= store.exists(mem.addr) ? store[mem.addr] : 16'h0000;
		end else
			waited <= waited + 2'h1;
	end
endmodule : tca_mem_model

// ---- tb/tca_ctl_tb.sv ----
`timescale 1ns/1ns
module tca_ctl_tb;
	logic                     clk = 1'b0;
	logic                     rst = 1'b1;
	logic                     module_stop_wr = 1'b0;
	logic                     module_stop_data = 1'b1;
	logic [7:0]               irq_req = 8'h00;
	logic [7:0]               raise = 8'h00;
	logic                     te_wr = 1'b0;
	logic                     te_set = 1'b0;
	logic [2:0]               te_idx = 3'h0;
	logic                     te_bulk_wr = 1'b0;
	logic [7:0]               te_bulk_data = 8'h00;
	logic                     sv_wr = 1'b0;
	logic [7:0]               sv_wdata = 8'h00;
	logic [1:0]               mem_delay = 2'h0;
	logic [15:0]              lfsr = 16'h37b5;
	logic                     mem_ack, module_stop, soft_transfer_end_irq, busy;
	logic [15:0]              mem_rdata;
	tca_pkg::tca_mem_req_type mem;
	logic [7:0]               transfer_enable_bank, cpu_irq, flag_clear, soft_vector_register;
	logic [15:0]              w [4];
	int                       n_errors = 0;
	int                       compares = 0;
	int                       cycles = 0;

	always #2 clk = ~clk;
	// Peripheral flags drop one cycle after the clear pulse
	always @(posedge clk) irq_req <= rst ? 8'h00 : (irq_req | raise) & ~flag_clear;

	tca_ctl #(.N_SRC(8)) u_tca_ctl (
		.clk(clk), .rst(rst), .ce(1'b1), .module_stop_wr(module_stop_wr),
		.module_stop_data(module_stop_data), .irq_req(irq_req), .te_wr(te_wr), .te_set(te_set),
		.te_idx(te_idx), .te_bulk_wr(te_bulk_wr), .te_bulk_data(te_bulk_data), .sv_wr(sv_wr),
		.sv_wdata(sv_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem(mem),
		.module_stop(module_stop), .transfer_enable_bank(transfer_enable_bank),
		.soft_vector_register(soft_vector_register), .cpu_irq(cpu_irq),
		.soft_transfer_end_irq(soft_transfer_end_irq), .flag_clear(flag_clear), .busy(busy)
	);
	tca_mem_model u_tca_mem_model (
		.clk(clk), .rst(rst), .mem(mem), .delay(mem_delay), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata)
	);

	// ------
	// Helpers
	// ------
	function automatic logic [15:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction : rnd
	function automatic logic [7:0] ma(input logic [1:0] s, d, m, input logic t, z);
		return {s, d, m, t, z};
	endfunction : ma
	task automatic end_of_test();
		$display("counts: compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	// Kind 0 module stop, 1 single enable bit, 2 soft vector, 3 whole bank
	task automatic host_wr(input logic [1:0] kind, input logic [7:0] d);
		@(posedge clk);
		mem_delay <= lfsr[1:0];
		module_stop_wr <= kind == 2'h0;
		module_stop_data <= d[0];
		te_wr <= kind == 2'h1;
		te_set <= d[7];
		te_idx <= d[2:0];
		sv_wr <= kind == 2'h2;
		sv_wdata <= d;
		te_bulk_wr <= kind == 2'h3;
		te_bulk_data <= d;
		@(posedge clk);
		{module_stop_wr, te_wr, sv_wr, te_bulk_wr} <= 4'h0;
		@(negedge clk);
	endtask : host_wr
	task automatic fire(input logic [2:0] idx);
		@(posedge clk);
		raise <= 8'h01 << idx;
		mem_delay <= lfsr[1:0];
		@(posedge clk);
		raise <= 8'h00;
	endtask : fire
	task automatic wait_done();
		int i;
		i = 0;
		while (busy !== 1'b1 && i < 20) begin
			@(negedge clk);
			i++;
		end
		i = 0;
		while (busy !== 1'b0 && i < 600) begin
			@(negedge clk);
			i++;
		end
		if (i == 600)
			chk(24'h1, 24'h0, "sequence did not finish");
		repeat (2) @(negedge clk);
	endtask : wait_done
	task automatic put_desc(input logic [23:0] a, input logic [6:0] vec, input logic [7:0] mda,
			input logic [7:0] mdb, input logic [23:0] s, d, input logic [15:0] ca, cb);
		if (vec != 7'h00)
			u_tca_mem_model.store[24'h000400 + {16'h0000, vec, 1'b0}] = a[15:0];
		u_tca_mem_model.store[a] = {mda, s[23:16]};
		u_tca_mem_model.store[a + 24'h2] = s[15:0];
		u_tca_mem_model.store[a + 24'h4] = {mdb, d[23:16]};
		u_tca_mem_model.store[a + 24'h6] = d[15:0];
		u_tca_mem_model.store[a + 24'h8] = ca;
		u_tca_mem_model.store[a + 24'ha] = cb;
	endtask : put_desc

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			$display("[ERR] %0t run exceeded its cycle budget", $time);
			end_of_test();
		end
	end

	// ------
	// Scenarios
	// ------
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk(module_stop, 1'b1, "halted after reset");
		chk(transfer_enable_bank, 8'h00, "enable bank reset");
		host_wr(2'h1, 8'h80);
		chk(transfer_enable_bank, 8'h00, "write taken while halted");
		host_wr(2'h0, 8'h00);
		host_wr(2'h3, 8'h01);
		$display("test reset and halt done");
		// Byte receive: fixed source, incrementing destination, count 3
		put_desc(24'hff8000, 7'h10, ma(2'h0, 2'h2, 2'h0, 1'b0, 1'b0), 8'h00,
			24'h001000, 24'h002000, 16'h0003, 16'h0000);
		for (int k = 0; k < 3; k++) begin
			w[0] = rnd();
			u_tca_mem_model.store[24'h001000] = w[0];
			fire(3'h0);
			wait_done();
			chk(u_tca_mem_model.store[24'h002000 + 24'(k)], {8'h00, w[0][7:0]}, "byte");
			chk(irq_req[0], k == 2, "source flag");
			chk(transfer_enable_bank[0], k != 2, "enable bit");
			chk(cpu_irq[0], k == 2, "cpu request");
		end
		chk(u_tca_mem_model.store[24'hff8006], 16'h2003, "dest written back");
		chk(u_tca_mem_model.store[24'hff8008], 16'h0000, "count written back");
		fire(3'h1);
		repeat (3) @(negedge clk);
		chk(busy, 1'b0, "disabled source started");
		chk(cpu_irq[1], 1'b1, "disabled source not passed");
		$display("test interrupt activation done");
		// Soft block of four words, destination is the block area
		put_desc(24'hff8040, 7'h60, ma(2'h2, 2'h2, 2'h2, 1'b0, 1'b1), 8'h00,
			24'h003000, 24'h004000, 16'h0404, 16'h0001);
		for (int k = 0; k < 4; k++) begin
			w[k] = rnd();
			u_tca_mem_model.store[24'h003000 + 24'(2 * k)] = w[k];
		end
		chk(soft_vector_register[7], 1'b0, "soft bit idle");
		host_wr(2'h2, 8'he0);
		chk(soft_vector_register, 8'he0, "vector readback");
		wait_done();
		for (int k = 0; k < 4; k++)
			chk(u_tca_mem_model.store[24'h004000 + 24'(2 * k)], w[k], "block word");
		chk(u_tca_mem_model.store[24'hff8042], 16'h3008, "source stepped");
		chk(u_tca_mem_model.store[24'hff8046], 16'h4000, "block area rewound");
		chk(soft_vector_register[7], 1'b1, "soft bit kept");
		chk(soft_transfer_end_irq, 1'b1, "soft end raised");
		host_wr(2'h2, 8'h60);
		chk(soft_transfer_end_irq, 1'b0, "soft end cleared");
		// Soft normal, per-transfer select off then on
		for (int j = 0; j < 2; j++) begin
			w[0] = rnd();
			u_tca_mem_model.store[24'h003000] = w[0];
			put_desc(24'hff8040, 7'h60, ma(2'h2, 2'h2, 2'h0, 1'b0, 1'b0), j ? 8'h40 : 8'h00,
				24'h003000, 24'h007000, 16'h0005, 16'h0000);
			host_wr(2'h2, 8'he0);
			wait_done();
			chk(u_tca_mem_model.store[24'h007000], {8'h00, w[0][7:0]}, "soft byte");
			chk(soft_vector_register, {j == 1, 7'h60}, "soft bit after one");
			chk(soft_transfer_end_irq, j == 1, "soft end on select");
			host_wr(2'h2, 8'h60);
		end
		$display("test soft activation done");
		// Chain: repeat word with select set, then normal word not at end
		put_desc(24'hff8080, 7'h12, ma(2'h2, 2'h0, 2'h1, 1'b1, 1'b1), 8'hc0,
			24'h005000, 24'h006000, 16'h0202, 16'h0000);
		put_desc(24'hff808c, 7'h00, ma(2'h2, 2'h0, 2'h0, 1'b0, 1'b1), 8'h00,
			24'h005100, 24'h006100, 16'h0002, 16'h0000);
		w[0] = rnd();
		w[1] = rnd();
		u_tca_mem_model.store[24'h005000] = w[0];
		u_tca_mem_model.store[24'h005100] = w[1];
		host_wr(2'h1, 8'h82);
		fire(3'h2);
		wait_done();
		chk(u_tca_mem_model.store[24'h006000], w[0], "first link word");
		chk(u_tca_mem_model.store[24'h006100], w[1], "second link word");
		chk(u_tca_mem_model.store[24'hff8094], 16'h0001, "second count back");
		chk(irq_req[2], 1'b0, "chain end cleared flag");
		chk(transfer_enable_bank[2], 1'b1, "chain kept enable");
		chk(cpu_irq[2], 1'b0, "chained select raised request");
		$display("test chain done");
		end_of_test();
	end
endmodule : tca_ctl_tb
